// ### bench/mid_modem.sv
// Modem model on the modem port
`timescale 1ns/10ps
module mid_modem (
  // Activity command and modem lines
  input  wire act,
  input  wire rts_only,
  output wire carrier_det,
  output wire req_send
);
  // Carrier line goes low when lost
  assign carrier_det = act;
  // Request to send may also be raised on its own
  assign req_send    = act | rts_only;
endmodule // mid_modem

// ### bench/mid_props_properties.sv
// Checker for the timer ports
`timescale 1ns/10ps
module mid_props (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Modem port
  input wire carrier_det,
  input wire req_send,
  input wire term_ready,
  // System mode
  input wire sys_online,
  input wire remote_ctl,
  input wire remote_req,
  input wire force_online,
  input wire force_offline,
  input wire disc_pulse,
  // Switches
  input wire sw1,
  input wire sw2,
  input wire sw3,
  input wire sw4
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_arm; disc_pulse |-> $past(sys_online) && $past(remote_ctl); endproperty
  a_arm: assert property (p_arm) else $error("arm");
  property p_drp; disc_pulse |-> sw3 && !term_ready; endproperty
  a_drp: assert property (p_drp) else $error("drop");
  property p_idl; disc_pulse |-> !$past(carrier_det, 8) && !$past(req_send, 8); endproperty
  a_idl: assert property (p_idl) else $error("busy");
  property p_hld; !sw3 && $past(!sw3) && $past(!sw3, 2) && $past(!sw3, 3) |-> term_ready;
  endproperty
  a_hld: assert property (p_hld) else $error("dtr");
  property p_fon; force_online |-> sw4 && !sys_online && $past(remote_req, 3); endproperty
  a_fon: assert property (p_fon) else $error("fon");
  property p_sw4; !sw4 |-> !force_online; endproperty
  a_sw4: assert property (p_sw4) else $error("sw4");
  property p_ret; force_offline |-> disc_pulse; endproperty
  a_ret: assert property (p_ret) else $error("foff");
  property p_rst; carrier_det || req_send |-> ##3 !disc_pulse [*8]; endproperty
  a_rst: assert property (p_rst) else $error("restart");
endmodule // mid_props

// ### bench/tb.sv
// Testbench for the inactivity timer
`timescale 1ns/10ps
module tb;
  reg mclk=0, rst_n=0, sys_online=0, remote_ctl=0, remote_req=0, act=1, sw1=0, sw2=0, sw3=1;
  reg sw4=0, rts_only=0;
  wire carrier_det, req_send, term_ready, force_online, force_offline, disc_pulse;
  integer fail_count=0, checked=0, n, nf=0, no=0, nf0, no0;
  always #5 mclk = ~mclk;
  // Count output pulses
  always @(posedge mclk) begin nf <= nf + force_online; no <= no + force_offline; end
  mid_modem u_mdm (.*);
  mid_timer #(.TICK_CYC(17'h0_0004), .DLY_A(16'h0003), .DLY_B(16'h0005),
    .DLY_C(16'h0007)) u_dut (.*);
  task chk(input [31:0] nm, input [7:0] s, e);
    begin checked = checked + 1;
      if (s !== e) begin fail_count = fail_count + 1; $display("ERROR %0s %h %h", nm, e, s); end
    end
  endtask
  // Wait for a disconnect, bounded
  task wd;
    begin n = 0; while (disc_pulse !== 1 && n < 99) begin @(negedge mclk); n = n + 1; end end
  endtask
  task t_dly(input a, b, input integer k);
    begin sw1 = a; sw2 = b; sys_online = 1; remote_ctl = 1;
      act = 1; repeat (5) @(negedge mclk); act = 0; wd;
      chk("dly", sw3 ? n >= k * 4 && n <= k * 4 + 6 : n == 99, 1);
      chk("drop", term_ready, !sw3);
      sys_online = 0; repeat (4) @(negedge mclk);
      chk("dtr", term_ready, 1);
    end
  endtask
  // Request to send alone, mid period, must restart the count
  task t_rts;
    begin sw1 = 1; sw2 = 1; sys_online = 1; remote_ctl = 1; act = 0;
      repeat (8) @(negedge mclk); rts_only = 1; repeat (3) @(negedge mclk);
      rts_only = 0; wd;
      chk("rts", n >= 12 && n <= 18, 1);
      sys_online = 0; repeat (4) @(negedge mclk);
    end
  endtask
  task t_rem(input s);
    begin sw4 = s; nf0 = nf; no0 = no; remote_req = 1; repeat (6) @(negedge mclk);
      remote_req = 0; chk("fon", nf - nf0, s);
      sys_online = s; remote_ctl = s; wd; @(negedge mclk);
      chk("foff", no - no0, s);
      sys_online = 0;
    end
  endtask
  task test_done;
    begin if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
      $finish; end
  endtask
  initial begin
    repeat (20) @(negedge mclk); rst_n = 1;
    t_dly(1, 1, 3); t_dly(1, 0, 5); t_dly(0, 1, 7); t_dly(0, 0, 7); t_rts;
    sw3 = 0; t_dly(1, 1, 3); sw3 = 1; t_rem(0); t_rem(1); test_done;
  end
  initial begin #30000; fail_count = fail_count + 1; test_done; end
endmodule // tb
bind mid_timer mid_props u_chk (.*);

// ### hw/mid_defs.vh
// Constants for the modem inactivity disconnect timer
// Operation
// - Acts only on-line, remote-controlled, unattended
// - Disconnect modem after preset inactivity period
// - Two switches select 10, 15 or 50 s
// - Switch 3 off holds terminal ready on
// - Remote interrupt aborts off-line, goes on-line
// - At disconnect time, return to off-line if on-line entry came from the remote interrupt
// - Switch 4 enables the off-line interrupt
`ifndef MID_DEFS_VH
`define MID_DEFS_VH
// Clock rate in kHz
`define MID_CLK_KHZ        100000
// Tick period in ms, cycles per tick
`define MID_TICK_MS        1
`define MID_TICK_CYC       (`MID_CLK_KHZ * `MID_TICK_MS)
// Delay periods in seconds
`define MID_DLY_A_S        10
`define MID_DLY_B_S        15
`define MID_DLY_C_S        50
// Delay periods in ticks
`define MID_DLY_A_TK       (`MID_DLY_A_S * 1000 / `MID_TICK_MS)
`define MID_DLY_B_TK       (`MID_DLY_B_S * 1000 / `MID_TICK_MS)
`define MID_DLY_C_TK       (`MID_DLY_C_S * 1000 / `MID_TICK_MS)
// Counter widths
`define MID_TICK_W         17
`define MID_CNT_W          16
// Synchroniser width and bit positions of the asynchronous pins
`define MID_SYNC_W         7
`define MID_B_CD           0
`define MID_B_RTS          1
`define MID_B_RQ           2
`define MID_B_SW1          3
`define MID_B_SW2          4
`define MID_B_SW3          5
`define MID_B_SW4          6
// Reset values
`define MID_SYNC_RST       1'b0
`define MID_PRE_RST        17'h0_0000
`define MID_CNT_RST        16'h0000
`define MID_DTR_RST        1'b1
`define MID_PULSE_RST      1'b0
`define MID_INTR_RST       1'b0
`endif

// ### hw/mid_timer.v
// Modem inactivity disconnect timer with remote interrupt
`timescale 1ns/10ps
`include "mid_defs.vh"
module mid_timer #(
  parameter [16:0] TICK_CYC = `MID_TICK_CYC,  // Cycles per 1 ms tick
  parameter [15:0] DLY_A    = `MID_DLY_A_TK,  // 10 s in ticks
  parameter [15:0] DLY_B    = `MID_DLY_B_TK,  // 15 s in ticks
  parameter [15:0] DLY_C    = `MID_DLY_C_TK   // 50 s in ticks
) (
  // Clock and reset
  input  wire mclk,
  input  wire rst_n,
  // Modem port pins, asynchronous
  input  wire carrier_det,     // High while carrier present
  input  wire req_send,        // High while request to send active
  output reg  term_ready,      // Data terminal ready to modem
  // System mode
  input  wire sys_online,      // System is on-line
  input  wire remote_ctl,      // Under remote control, local unattended
  input  wire remote_req,      // Remote interrupt request pulse, pin
  output reg  force_online,    // One-cycle pulse: abort and go on-line
  output reg  force_offline,   // One-cycle pulse: return off-line
  output reg  disc_pulse,      // One-cycle pulse: disconnect happened
  // Rocker switches, static, high means ON
  input  wire sw1,
  input  wire sw2,
  input  wire sw3,
  input  wire sw4
);


  // Raw asynchronous pins gathered into one vector
  wire [`MID_SYNC_W-1:0] pin_raw;      // Pins as they arrive
  // Synchronised copies of the same pins
  wire [`MID_SYNC_W-1:0] pin_sync;     // Second-stage outputs

  // Edge detector for the remote request
  reg                    req_d_r;      // Synced request, one cycle late

  // Timer state
  reg  [`MID_TICK_W-1:0] pre_r;        // Prescaler to the 1 ms tick
  reg  [`MID_TICK_W-1:0] pre_nxt;      // Next prescaler value
  reg  [`MID_CNT_W-1:0]  cnt_r;        // Count of idle ticks
  reg  [`MID_CNT_W-1:0]  cnt_nxt;      // Next idle tick count
  reg                    intr_r;       // On-line entry came from remote interrupt
  reg  [`MID_CNT_W-1:0]  lim;          // Selected period in ticks

  // Synchronised pin views
  wire                   cd_s;         // Carrier present
  wire                   rts_s;        // Request to send active
  wire                   rq_s;         // Remote interrupt request level
  wire                   sw1_s;        // Period switch 1
  wire                   sw2_s;        // Period switch 2
  wire                   sw3_s;        // Disconnect permit switch
  wire                   sw4_s;        // Remote interrupt enable switch

  // Decoded conditions
  wire                   active;       // Line is in use
  wire                   armed;        // Timer allowed to run
  wire                   tick;         // Last cycle of a 1 ms tick
  wire                   last_tick;    // Count has reached the last tick of the period
  wire                   expire;       // Inactivity period has run out
  wire                   req_rise;     // Accepted remote interrupt request

  // Gather the pins; order follows the bit positions in the header
  assign pin_raw[`MID_B_CD]  = carrier_det;
  assign pin_raw[`MID_B_RTS] = req_send;
  assign pin_raw[`MID_B_RQ]  = remote_req;
  assign pin_raw[`MID_B_SW1] = sw1;
  assign pin_raw[`MID_B_SW2] = sw2;
  assign pin_raw[`MID_B_SW3] = sw3;
  assign pin_raw[`MID_B_SW4] = sw4;

  // Two-flop synchroniser per pin; only the second flop is read
  genvar gi;
  generate
    for (gi = 0; gi < `MID_SYNC_W; gi = gi + 1) begin : g_sync
      reg s1_r;                        // First stage, may go metastable
      reg s2_r;                        // Second stage, safe to use

      // Shift the pin through both stages
      always @(posedge mclk) begin
        if (!rst_n) begin
          // Clear both stages
          s1_r <= `MID_SYNC_RST;
          s2_r <= `MID_SYNC_RST;
        end else begin
          // Sample the pin, then settle it
          s1_r <= pin_raw[gi];
          s2_r <= s1_r;
        end
      end

      assign pin_sync[gi] = s2_r;
    end
  endgenerate

  // Pick the synchronised views apart
  assign cd_s  = pin_sync[`MID_B_CD];  // High means carrier, low means lost
  assign rts_s = pin_sync[`MID_B_RTS];
  assign rq_s  = pin_sync[`MID_B_RQ];
  assign sw1_s = pin_sync[`MID_B_SW1];
  assign sw2_s = pin_sync[`MID_B_SW2];
  assign sw3_s = pin_sync[`MID_B_SW3];
  assign sw4_s = pin_sync[`MID_B_SW4];

  // Either modem line active counts as traffic
  assign active    = cd_s | rts_s;
  // Timer only runs on-line under remote control
  assign armed     = sys_online & remote_ctl;
  // Prescaler wraps at the end of each tick
  assign tick      = (pre_r == TICK_CYC - 17'h0_0001);
  // Compare with the selected period; >= covers a switch change
  assign last_tick = (cnt_r >= lim - 16'h0001);
  // Period over while still armed and idle
  assign expire    = armed & ~active & tick & last_tick;
  // Remote request edge, only when enabled and off-line
  assign req_rise  = sw4_s & rq_s & ~req_d_r & ~sys_online;

  // Period select from switches 1 and 2
  always @* begin
    case ({sw1_s, sw2_s})
      // Both on: shortest period
      2'b11: begin
        lim = DLY_A;
      end
      // First on, second off: middle period
      2'b10: begin
        lim = DLY_B;
      end
      // First off, second on: long period
      2'b01: begin
        lim = DLY_C;
      end
      // Both off is not a listed setting; take the longest period
      default: begin
        lim = DLY_C;
      end
    endcase
  end

  // Next values of the prescaler and the idle counter
  always @* begin
    pre_nxt = pre_r;
    cnt_nxt = cnt_r;
    if (!armed || active) begin
      // Traffic or de-arming starts the period over
      pre_nxt = `MID_PRE_RST;
      cnt_nxt = `MID_CNT_RST;
    end else if (tick) begin
      // End of a tick: wrap prescaler, advance count
      pre_nxt = `MID_PRE_RST;
      if (expire) begin
        // Period over: start a fresh one
        cnt_nxt = `MID_CNT_RST;
      end else begin
        // One more idle tick
        cnt_nxt = cnt_r + 16'h0001;
      end
    end else begin
      // Inside a tick: keep counting cycles
      pre_nxt = pre_r + 17'h0_0001;
    end
  end

  // Prescaler and idle counter registers
  always @(posedge mclk) begin
    if (!rst_n) begin
      // Clear the whole timer
      pre_r <= `MID_PRE_RST;
      cnt_r <= `MID_CNT_RST;
    end else begin
      // Take the next values
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Disconnect, ready line and remote interrupt control
  always @(posedge mclk) begin
    if (!rst_n) begin
      // Ready high, no pulses, no pending interrupt
      term_ready    <= `MID_DTR_RST;
      force_online  <= `MID_PULSE_RST;
      force_offline <= `MID_PULSE_RST;
      disc_pulse    <= `MID_PULSE_RST;
      intr_r        <= `MID_INTR_RST;
      req_d_r       <= `MID_PULSE_RST;
    end else begin
      // Remember the request level for the edge detector
      req_d_r       <= rq_s;
      // Disconnect only when switch 3 permits it
      disc_pulse    <= expire & sw3_s;
      // Return off-line at the disconnect moment, if entered remotely
      force_offline <= expire & sw3_s & intr_r;
      // Abort off-line work and go on-line
      force_online  <= req_rise;
      if (!sw3_s) begin
        // Switch 3 off: ready line held on
        term_ready <= 1'b1;
      end else if (expire) begin
        // Drop the ready line so the modem hangs up
        term_ready <= 1'b0;
      end else if (!sys_online) begin
        // Off-line again: ready for the next call
        term_ready <= 1'b1;
      end
      if (req_rise) begin
        // On-line entry came from the remote interrupt
        intr_r <= 1'b1;
      end else if (expire) begin
        // Interrupt session ends with the period
        intr_r <= 1'b0;
      end
    end
  end

endmodule // mid_timer
